// File: core/bpg_pkg.sv
// Purpose: Shared constants for the burst preamble generator.
// Assumes: One preamble string per channel, at most 1024 bits.
// Notes:   Bit positions are zero-based inside the design.
package bpg_pkg;
   localparam int          STR_BITS   = 1024;
   localparam int          ADDR_W     = 10;
   localparam int          LEN_W      = 11;
   localparam int          SUM_W      = 12;
   localparam logic [10:0] STR_LEN_RST = 11'h000;
   localparam logic [9:0]  ADDR_RST    = 10'h000;
   localparam logic [10:0] COUNT_RST   = 11'h000;
   localparam logic [10:0] COUNT_ONE   = 11'h001;
   localparam int          RD_LATENCY  = 1;
   typedef enum logic [1:0] {BPG_IDLE, BPG_FETCH, BPG_HOLD} bpg_state_t;
endpackage : bpg_pkg

// File: core/bpg_mem_if.sv
// Purpose: Carrier between the preamble sequencer and its bit store.
// Assumes: One write port and one read port on the same clock.
// Notes:   Read data are valid one cycle after a read enable.
`timescale 1ns/1ps
interface bpg_mem_if #(parameter int ADDR_W = 10);
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic              wr_data;
   logic              rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic              rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : bpg_mem_if

// File: core/bpg_mem.sv
// Purpose: Single-bit wide store holding the channel preamble string.
// Assumes: Synchronous write, registered read.
// Notes:   Read data hold their value until the next read enable; reset clears them.
`timescale 1ns/1ps
module bpg_mem #(
   parameter int DEPTH  = bpg_pkg::STR_BITS,
   parameter int ADDR_W = bpg_pkg::ADDR_W
) (
   input wire logic clk_in,
   input wire logic reset_in,
   bpg_mem_if.mem   port
);
   logic store [DEPTH];

   always_ff @(posedge clk_in) begin
      if (port.wr_en) begin
         store[port.wr_addr] <= port.wr_data;
      end
   end

   // Registered read keeps the mapper bit straight off a flop
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         port.rd_data <= 1'b0;
      end else if (port.rd_en) begin
         port.rd_data <= store[port.rd_addr];
      end
   end
endmodule : bpg_mem

// File: core/bpg_top.sv
// Purpose: Feeds the selected slice of the preamble string into the symbol mapper.
// Assumes: Synchronous inputs on clk_in; string loaded while no burst runs.
// Notes:   One bit every two cycles at most, because each bit is read from the store first.
`timescale 1ns/1ps
module bpg_top #(
   parameter int STR_BITS = bpg_pkg::STR_BITS,
   parameter int ADDR_W   = bpg_pkg::ADDR_W,
   parameter int LEN_W    = bpg_pkg::LEN_W
) (
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   // String load
   input  wire logic              load_valid_in,
   input  wire logic [ADDR_W-1:0] load_addr_in,
   input  wire logic              load_bit_in,
   output logic                   load_ready_out,
   input  wire logic [LEN_W-1:0]  str_len_in,
   input  wire logic              str_len_set_in,
   // Burst request from the active profile
   input  wire logic              burst_start_in,
   input  wire logic [ADDR_W-1:0] offset_in,
   input  wire logic [LEN_W-1:0]  length_in,
   output logic                   burst_ready_out,
   output logic                   cfg_error_out,
   output logic                   busy_out,
   // Mapper side
   output logic                   bit_valid_out,
   input  wire logic              mapper_ready_in,
   output logic                   bit_out,
   output logic                   bit_q_out,
   output logic                   bit_first_out,
   output logic                   bit_last_out
);
   bpg_pkg::bpg_state_t state;
   bpg_pkg::bpg_state_t next_state;
   logic [LEN_W-1:0]  str_len;
   logic [ADDR_W-1:0] cur_addr;
   logic [LEN_W-1:0]  remain;
   logic              q_phase;
   logic              first;
   logic              cfg_ok;
   logic              start_take;
   logic              shift;
   logic [bpg_pkg::SUM_W-1:0] slice_end;

   bpg_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

   bpg_mem #(
      .DEPTH  (STR_BITS),
      .ADDR_W (ADDR_W)
   ) u_mem (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .port     (mem_bus.mem)
   );

   assign load_ready_out  = (state == bpg_pkg::BPG_IDLE) && !burst_start_in;
   assign burst_ready_out = (state == bpg_pkg::BPG_IDLE);
   assign busy_out        = (state != bpg_pkg::BPG_IDLE);
   assign bit_valid_out   = (state == bpg_pkg::BPG_HOLD);
   assign bit_out         = mem_bus.rd_data;
   assign bit_q_out       = q_phase;
   assign bit_first_out   = first;
   assign bit_last_out    = (remain == bpg_pkg::COUNT_ONE);
   assign shift           = bit_valid_out && mapper_ready_in;
   assign start_take      = burst_start_in && burst_ready_out;

   // shared string store
   // Loads are held off during a burst so the string never changes under it
   assign mem_bus.wr_en   = load_valid_in && load_ready_out;
   assign mem_bus.wr_addr = load_addr_in;
   assign mem_bus.wr_data = load_bit_in;
   assign mem_bus.rd_en   = (state == bpg_pkg::BPG_FETCH);
   assign mem_bus.rd_addr = cur_addr;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         str_len <= bpg_pkg::STR_LEN_RST;
      end else if (str_len_set_in && load_ready_out) begin
         str_len <= str_len_in;
      end
   end

   // slice bound check
   // An empty slice is refused as well, since it would give a burst with no preamble
   assign slice_end = {1'b0, offset_in} + {1'b0, length_in};
   assign cfg_ok    = (length_in != bpg_pkg::COUNT_RST) && (slice_end <= {1'b0, str_len})
                      && (str_len <= LEN_W'(STR_BITS));

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cfg_error_out <= 1'b0;
      end else begin
         cfg_error_out <= start_take && !cfg_ok;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         bpg_pkg::BPG_IDLE: begin
            if (start_take && cfg_ok) begin
               next_state = bpg_pkg::BPG_FETCH;
            end
         end
         bpg_pkg::BPG_FETCH: begin
            next_state = bpg_pkg::BPG_HOLD;
         end
         bpg_pkg::BPG_HOLD: begin
            if (shift) begin
               next_state = bit_last_out ? bpg_pkg::BPG_IDLE : bpg_pkg::BPG_FETCH;
            end
         end
         // Unused fourth code falls back to idle rather than locking up
         default: begin
            next_state = bpg_pkg::BPG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= bpg_pkg::BPG_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cur_addr <= bpg_pkg::ADDR_RST;
         remain   <= bpg_pkg::COUNT_RST;
      end else if (start_take && cfg_ok) begin
         cur_addr <= offset_in;
         remain   <= length_in;
      end else if (shift) begin
         cur_addr <= cur_addr + ADDR_W'(1);
         remain   <= remain - bpg_pkg::COUNT_ONE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q_phase <= 1'b0;
         first   <= 1'b0;
      end else if (start_take && cfg_ok) begin
         q_phase <= 1'b0;
         first   <= 1'b1;
      end else if (shift) begin
         q_phase <= !q_phase;
         first   <= 1'b0;
      end
   end

   // Assertions
   // no string change mid-burst
   AST_LOAD_IDLE: assert property (@(posedge clk_in) disable iff (reset_in)
      mem_bus.wr_en |-> state == bpg_pkg::BPG_IDLE)
      else $error("string written during a burst");

   AST_COUNT_TAKEN: assert property (@(posedge clk_in) disable iff (reset_in)
      start_take && cfg_ok |=> remain == $past(length_in) && state == bpg_pkg::BPG_FETCH)
      else $error("burst count not taken from profile");

   AST_FIRST_ADDR: assert property (@(posedge clk_in) disable iff (reset_in)
      start_take && cfg_ok |=> mem_bus.rd_en && mem_bus.rd_addr == $past(offset_in))
      else $error("first read not at offset");

   AST_FIRST_IS_I: assert property (@(posedge clk_in) disable iff (reset_in)
      start_take && cfg_ok |=> ##1 bit_valid_out && bit_first_out && !bit_q_out)
      else $error("first preamble bit not presented as I");

   AST_IQ_TOGGLE: assert property (@(posedge clk_in) disable iff (reset_in)
      shift && !bit_last_out |-> ##2 bit_valid_out && (bit_q_out != $past(bit_q_out, 2)))
      else $error("I and Q phases did not alternate");

   AST_ADDR_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
      shift && !bit_last_out |=> mem_bus.rd_addr == $past(cur_addr) + ADDR_W'(1))
      else $error("string bits not read in order");

   AST_BAD_CFG: assert property (@(posedge clk_in) disable iff (reset_in)
      start_take && !cfg_ok |=> cfg_error_out && !busy_out && !bit_valid_out)
      else $error("invalid profile not refused");

   AST_ERR_PULSE: assert property (@(posedge clk_in) disable iff (reset_in)
      !(start_take && !cfg_ok) |=> !cfg_error_out)
      else $error("error flag without a refused start");

   AST_HOLD_STABLE: assert property (@(posedge clk_in) disable iff (reset_in)
      bit_valid_out && !mapper_ready_in |=> bit_valid_out && $stable(bit_out) && $stable(bit_q_out))
      else $error("presented bit changed before the mapper took it");

   AST_IN_STRING: assert property (@(posedge clk_in) disable iff (reset_in)
      mem_bus.rd_en |-> {1'b0, cur_addr} < str_len)
      else $error("read past end of string");

   COV_BURST_DONE: cover property (@(posedge clk_in) disable iff (reset_in)
      shift && bit_last_out && bit_q_out);
   COV_STALL: cover property (@(posedge clk_in) disable iff (reset_in)
      bit_valid_out && !mapper_ready_in ##1 shift);
   COV_BAD_CFG: cover property (@(posedge clk_in) disable iff (reset_in)
      cfg_error_out);
   COV_ONE_BIT: cover property (@(posedge clk_in) disable iff (reset_in)
      shift && bit_first_out && bit_last_out);
endmodule : bpg_top

// File: verif/bpg_mapper_model.sv
// Purpose: Symbol mapper stand-in that takes preamble bits.
// Assumes: Bits are taken on valid and ready at a rising edge.
// Notes:   Slow mode takes one bit in four cycles to stretch bursts.
`timescale 1ns/1ps
module bpg_mapper_model (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic valid_in,
   input  wire logic bit_in,
   input  wire logic q_in,
   input  wire logic first_in,
   input  wire logic last_in,
   input  wire logic stall_in,
   output logic      ready_out
);
   logic [3:0] rx_q[$];
   logic [1:0] phase;
   always @(posedge clk_in) begin
      phase <= reset_in ? 2'h0 : phase + 2'h1;
      ready_out <= !stall_in || (phase == 2'h3);
      if (!reset_in && valid_in && ready_out) begin
         rx_q.push_back({bit_in, q_in, first_in, last_in});
      end
   end
endmodule : bpg_mapper_model

// File: verif/tb_burst_preamble_generator.sv
// Purpose: Self-checking bench for the preamble generator.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Expected bits come from the same pattern loaded into the store.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %0t bad value", $time); end end
module tb_burst_preamble_generator;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic        ld_v = 1'b0;
   logic [9:0]  ld_a = 10'h000;
   logic        ld_b = 1'b0;
   logic [10:0] s_len = 11'h000;
   logic        s_set = 1'b0;
   logic        start = 1'b0;
   logic [9:0]  off = 10'h000;
   logic [10:0] len = 11'h000;
   logic        stall = 1'b0;
   logic        ld_r, b_r, err, busy, v, rdy, b, q, f, l;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc = 0;
   always #5 clk_in = ~clk_in;
   bpg_top dut_u (.clk_in(clk_in), .reset_in(reset_in), .load_valid_in(ld_v), .load_addr_in(ld_a),
      .load_bit_in(ld_b), .load_ready_out(ld_r), .str_len_in(s_len), .str_len_set_in(s_set),
      .burst_start_in(start), .offset_in(off), .length_in(len), .burst_ready_out(b_r),
      .cfg_error_out(err), .busy_out(busy), .bit_valid_out(v), .mapper_ready_in(rdy),
      .bit_out(b), .bit_q_out(q), .bit_first_out(f), .bit_last_out(l));
   bpg_mapper_model mdl_u (.clk_in(clk_in), .reset_in(reset_in), .valid_in(v), .bit_in(b), .q_in(q),
      .first_in(f), .last_in(l), .stall_in(stall), .ready_out(rdy));
   function automatic logic pat(input int i);
      return i[0] ^ i[2] ^ i[5] ^ i[9];
   endfunction : pat
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // Ceiling well above the roughly 1350 cycles the tests take
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic set_len(input logic [10:0] n);
      @(posedge clk_in) s_len <= n;
      s_set <= 1'b1;
      @(posedge clk_in) s_set <= 1'b0;
   endtask : set_len
   task automatic run_burst(input int o, input int n, input logic bad, input logic slow);
      logic [3:0] e;
      stall = slow;
      mdl_u.rx_q.delete();
      @(posedge clk_in) start <= 1'b1;
      off <= o[9:0];
      len <= n[10:0];
      @(posedge clk_in) start <= 1'b0;
      #1 `CHK(err, bad)
      `CHK(busy, !bad)
      `CHK(b_r, bad)
      if (!bad) `CHK(ld_r, 1'b0)
      // A string write while busy, and in slow runs a start as well, must be ignored
      @(posedge clk_in) start <= slow;
      off <= 10'h000;
      ld_v <= !bad;
      ld_a <= 10'(o + n - 1);
      ld_b <= !pat(o + n - 1);
      @(posedge clk_in) start <= 1'b0;
      ld_v <= 1'b0;
      #1 `CHK(err, 1'b0)
      // Busy is looked at 1 ns after each edge, once the state has settled
      for (int k = 0; k < 8 * n + 8 && busy !== 1'b0; k++) begin
         @(posedge clk_in);
         #1;
      end
      `CHK(busy, 1'b0)
      `CHK(b_r, 1'b1)
      `CHK(err, 1'b0)
      `CHK(mdl_u.rx_q.size(), bad ? 0 : n)
      for (int i = 0; i < mdl_u.rx_q.size(); i++) begin
         e = mdl_u.rx_q[i];
         `CHK(e[3], pat(o + i))
         `CHK(e[2], i[0])
         `CHK(e[1], i == 0)
         `CHK(e[0], i == n - 1)
      end
      $display("test done offset %0d length %0d", o, n);
   endtask : run_burst
   // Reset in mid-burst must drop the burst and clear the string length
   task automatic reset_mid_burst();
      @(posedge clk_in) start <= 1'b1;
      off <= 10'h064;
      len <= 11'h014;
      @(posedge clk_in) start <= 1'b0;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      #1 `CHK(busy, 1'b0)
      `CHK(v, 1'b0)
      `CHK(b, 1'b0)
      `CHK(err, 1'b0)
      `CHK(ld_r, 1'b1)
      $display("test done reset in burst");
   endtask : reset_mid_burst
   initial begin
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      run_burst(0, 4, 1'b1, 1'b0);
      for (int i = 0; i < 1024; i++) begin
         @(posedge clk_in) ld_v <= 1'b1;
         ld_a <= i[9:0];
         ld_b <= pat(i);
      end
      @(posedge clk_in) ld_v <= 1'b0;
      #1 `CHK(ld_r, 1'b1)
      set_len(11'h400);
      run_burst(100, 5, 1'b0, 1'b0);
      run_burst(1019, 5, 1'b0, 1'b1);
      run_burst(1020, 5, 1'b1, 1'b0);
      run_burst(0, 0, 1'b1, 1'b0);
      run_burst(0, 1, 1'b0, 1'b0);
      set_len(11'h0C8);
      run_burst(150, 51, 1'b1, 1'b0);
      run_burst(150, 50, 1'b0, 1'b1);
      reset_mid_burst();
      // String length is cleared by reset, so the same profile is now refused
      run_burst(100, 5, 1'b1, 1'b0);
      set_len(11'h400);
      // The stored string survives reset
      run_burst(300, 7, 1'b0, 1'b0);
      give_verdict();
   end
endmodule : tb_burst_preamble_generator
